/* logic/charger_regs_pkg.sv */
package charger_regs_pkg;

    // register offsets on the serial register port
    localparam logic [7:0] ADDR_CHARGER_STATE_FLAGS  = 8'h0B;
    localparam logic [7:0] ADDR_BATTERY_THERMAL      = 8'h0C;
    localparam logic [7:0] ADDR_FAULT_FLAGS          = 8'h0D;
    localparam logic [7:0] ADDR_SHORT_DETECT_CONFIG  = 8'h10;

    // charger_state_flags fields
    localparam int BIT_INPUT_OVERVOLTAGE = 7;
    localparam int BIT_INPUT_GOOD        = 6;
    localparam int BIT_INPUT_CURR_LIM    = 5;
    localparam int BIT_THERMAL_LIMITED   = 4;
    localparam int BIT_CHARGE_DONE       = 3;

    // battery_thermal_state fields
    localparam int BIT_RECHARGE_NEEDED   = 3;

    // fault_flags fields
    localparam int BIT_BATTERY_SHORT     = 3;
    localparam int BIT_OVERTEMP_LOW      = 1;
    localparam int BIT_OVERTEMP_HIGH     = 0;
    localparam logic [7:0] FAULT_MASK    = 8'h0B;
    localparam logic [7:0] FAULT_RESET   = 8'h00;

    // short_detect_config fields: timeout [7:5], threshold [2:0]
    localparam int         SHORT_TIMEOUT_LSB = 5;
    localparam logic [7:0] SHORT_CFG_MASK    = 8'hE7;
    localparam logic [7:0] SHORT_CFG_RESET   = 8'h84;

    // short timeout per code, in seconds
    localparam logic [7:0][7:0] SHORT_TIMEOUT_SEC =
        {8'hB4, 8'h78, 8'h3C, 8'h1E, 8'h0A, 8'h04, 8'h02, 8'h01};

    // clock rate and the one-second tick derived from it
    localparam int unsigned CLK_HZ             = 25_000_000;
    localparam int unsigned TICK_SEC           = 1;
    localparam int unsigned SEC_CYCLES_DEFAULT = CLK_HZ * TICK_SEC;

    // charge state codes
    typedef enum logic [2:0] {
        CHG_OFF       = 3'h0,
        CHG_TRICKLE   = 3'h1,
        CHG_FAST_CC   = 3'h2,
        CHG_FAST_CV   = 3'h3,
        CHG_COMPLETE  = 3'h4,
        CHG_LINEAR    = 3'h5,
        CHG_TIMEOUT   = 3'h6,
        CHG_DETECTION = 3'h7
    } charge_code_t;

    // levels from the analogue comparators and the charge state machine
    typedef struct packed {
        logic         input_overvoltage_flag;
        logic         input_good_flag;
        logic         input_current_limited;
        logic         thermal_limited;
        charge_code_t charge_code;
        logic [2:0]   thermistor_state_code;
        logic [2:0]   battery_level_code;
        logic         recharge_disable;
        logic         below_recharge;
        logic         below_short;
        logic         overtemp_low_fault;
        logic         overtemp_high_fault;
    } analog_status_t;

    // one register access from the serial interface engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : charger_regs_pkg

/* logic/short_timer.sv */
`timescale 1ns/1ns
module short_timer #(
    parameter int unsigned SEC_CYCLES = charger_regs_pkg::SEC_CYCLES_DEFAULT
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       below,
    input  wire logic [2:0] timeout_code,
    output logic            fire
);
    import charger_regs_pkg::*;

    localparam int PW = $clog2(SEC_CYCLES + 1);

    typedef struct packed {
        logic [PW-1:0] presc;
        logic [7:0]    secs;
        logic          expired;
        logic          fire;
    } short_timer_state_t;

    short_timer_state_t state;
    short_timer_state_t next_state;

    // count whole seconds while the battery sits below the short threshold
    always_comb begin
        logic [7:0] next_secs;
        next_secs  = state.secs + 8'h01;
        next_state = state;
        next_state.fire = 1'b0;
        if (!below) begin
            // any rise above the threshold restarts the wait
            next_state.presc   = '0;
            next_state.secs    = 8'h00;
            next_state.expired = 1'b0;
        end else if (!state.expired) begin
            if (state.presc == PW'(SEC_CYCLES - 1)) begin
                next_state.presc = '0;
                next_state.secs  = next_secs;
                if (next_secs >= SHORT_TIMEOUT_SEC[timeout_code]) begin
                    next_state.expired = 1'b1; // [RULE16]
                    next_state.fire    = 1'b1;
                end
            end else begin
                next_state.presc = state.presc + PW'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign fire = state.fire;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_timer_idle: assert property (!below |=> !fire && state.secs == 8'h00) // [RULE16]
        else $error("short timer ran while battery above threshold");
    a_fire_once: assert property (fire |=> !fire) // [RULE16]
        else $error("short timer fired twice in a row");

endmodule : short_timer

/* logic/charger_status_fault_regs.sv */
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: status one bit 7 shows supply overvoltage and bit 6 shows supply above good level.
// RULE2: status one bit 5 shows input current held back by the blocking transistor.
// RULE3: status one bit 4 shows charge current cut back by die temperature.
// RULE4: status one bit 3 latches at end of charge and survives a drop below recharge level.
// RULE5: status one bits 2..0 give the eight charge state codes.
// RULE6: status two bits 7..5 give the thermistor state code.
// RULE7: status two bit 3 is live only with recharge disabled and charge state complete.
// RULE8: when live, status two bit 3 reads 1 below the recharge level and 0 above it.
// RULE9: status two bits 2..0 give the battery level code.
// RULE10: fault bit 3 sets on a battery short and resets to 0.
// RULE11: fault bits 1 and 0 set on the lower and higher overtemperature faults, reset 0.
// RULE12: fault bits hold until the host writes 1 to them or the supply is cycled.
// RULE13: config bits 7..5 pick the short timeout from 1 s to 180 s, reset code 100.
// RULE14: config bits 2..0 pick the short threshold 2.0 V to 2.7 V, reset code 100.
// RULE15: writes to status registers and unused bits do nothing, unused bits read 0.
// RULE16: the short fault sets once the battery stays under threshold for the timeout.
module charger_status_fault_regs #(
    parameter int unsigned SEC_CYCLES = charger_regs_pkg::SEC_CYCLES_DEFAULT
) (
    input  wire logic                             mclk,
    input  wire logic                             rst_n,
    input  wire charger_regs_pkg::analog_status_t status_in,
    input  wire charger_regs_pkg::reg_req_t       req,
    output logic [7:0]                            rdata,
    output logic [2:0]                            short_threshold_select,
    output logic [2:0]                            short_timeout_select
);
    import charger_regs_pkg::*;

    typedef struct packed {
        logic       charge_done;
        logic [7:0] fault;
        logic [7:0] cfg;
        logic [7:0] rdata;
        logic       input_good_prev;
    } regs_state_t;

    regs_state_t state;
    regs_state_t next_state;
    logic        short_fire;
    logic [7:0]  status_one;
    logic [7:0]  status_two;
    logic        recharge_live;

    // battery short wait runs in its own counter
    short_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_short_timer (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .below        (status_in.below_short),
        .timeout_code (state.cfg[7:5]),
        .fire         (short_fire)
    );

    // recharge info only means something after a completed charge with recharge off
    assign recharge_live = status_in.recharge_disable
                         && status_in.charge_code == CHG_COMPLETE; // [RULE7]

    // live status images; bit 4 of status two is unused and reads 0
    always_comb begin
        status_one = 8'h00;
        status_one[BIT_INPUT_OVERVOLTAGE] = status_in.input_overvoltage_flag; // [RULE1]
        status_one[BIT_INPUT_GOOD]        = status_in.input_good_flag;        // [RULE1]
        status_one[BIT_INPUT_CURR_LIM]    = status_in.input_current_limited;  // [RULE2]
        status_one[BIT_THERMAL_LIMITED]   = status_in.thermal_limited;        // [RULE3]
        status_one[BIT_CHARGE_DONE]       = state.charge_done;                // [RULE4]
        status_one[2:0]                   = status_in.charge_code;            // [RULE5]
        status_two = 8'h00;
        status_two[7:5] = status_in.thermistor_state_code;                    // [RULE6]
        status_two[BIT_RECHARGE_NEEDED] = recharge_live
                                        && status_in.below_recharge;          // [RULE8]
        status_two[2:0] = status_in.battery_level_code;                       // [RULE9]
    end

    // next state: latch, fault set/clear, config write, read mux
    always_comb begin
        next_state = state;
        next_state.input_good_prev = status_in.input_good_flag;

        // done latches on completion; only a fresh charge cycle drops it,
        // so falling under the recharge level leaves it standing
        if (status_in.charge_code == CHG_COMPLETE) begin
            next_state.charge_done = 1'b1; // [RULE4]
        end else if (status_in.charge_code == CHG_TRICKLE
                     || status_in.charge_code == CHG_FAST_CC
                     || status_in.charge_code == CHG_FAST_CV) begin
            next_state.charge_done = 1'b0;
        end

        // supply drop counts as a power cycle and wipes the faults
        if (state.input_good_prev && !status_in.input_good_flag) begin
            next_state.fault = FAULT_RESET; // [RULE12]
        end
        // write one to clear; status registers ignore writes
        if (req.wr && req.addr == ADDR_FAULT_FLAGS) begin
            next_state.fault = next_state.fault & ~(req.wdata & FAULT_MASK); // [RULE12]
        end
        // sets come last so an event in the clear cycle is kept
        if (short_fire) begin
            next_state.fault[BIT_BATTERY_SHORT] = 1'b1; // [RULE10]
        end
        if (status_in.overtemp_low_fault) begin
            next_state.fault[BIT_OVERTEMP_LOW] = 1'b1; // [RULE11]
        end
        if (status_in.overtemp_high_fault) begin
            next_state.fault[BIT_OVERTEMP_HIGH] = 1'b1; // [RULE11]
        end

        // unused config bits never store
        if (req.wr && req.addr == ADDR_SHORT_DETECT_CONFIG) begin
            next_state.cfg = req.wdata & SHORT_CFG_MASK; // [RULE13] [RULE14] [RULE15]
        end

        // read data lands one cycle after the strobe and then holds
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CHARGER_STATE_FLAGS: next_state.rdata = status_one;
                ADDR_BATTERY_THERMAL:     next_state.rdata = status_two;
                ADDR_FAULT_FLAGS:         next_state.rdata = state.fault & FAULT_MASK;
                ADDR_SHORT_DETECT_CONFIG: next_state.rdata = state.cfg;
                default:                  next_state.rdata = 8'h00; // [RULE15]
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state.charge_done     <= 1'b0;
            state.fault           <= FAULT_RESET;      // [RULE10] [RULE11]
            state.cfg             <= SHORT_CFG_RESET;  // [RULE13] [RULE14]
            state.rdata           <= 8'h00;
            state.input_good_prev <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata                  = state.rdata;
    assign short_timeout_select   = state.cfg[SHORT_TIMEOUT_LSB +: 3]; // [RULE13]
    assign short_threshold_select = state.cfg[2:0]; // [RULE14]

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // one read strobe aimed at one address
    sequence s_read(logic [7:0] a);
        req.rd && req.addr == a;
    endsequence

    // one write strobe aimed at one address
    sequence s_write(logic [7:0] a);
        req.wr && req.addr == a;
    endsequence

    // a write of one to a single fault bit
    sequence s_clear_fault(int b);
        req.wr && req.addr == ADDR_FAULT_FLAGS && req.wdata[b];
    endsequence

    // supply good falling, which the block treats as a power cycle
    sequence s_supply_drop;
        state.input_good_prev && !status_in.input_good_flag;
    endsequence

    // status one: each field shows the level sampled with the strobe
    a_supply_flags_read: assert property (s_read(ADDR_CHARGER_STATE_FLAGS) |=> // [RULE1]
            rdata[7:6] == $past({status_in.input_overvoltage_flag, status_in.input_good_flag}))
        else $error("supply flags read wrong");

    a_ilim_read: assert property (s_read(ADDR_CHARGER_STATE_FLAGS) |=> // [RULE2]
            rdata[5] == $past(status_in.input_current_limited))
        else $error("input limit flag read wrong");

    a_limit_flags_read: assert property (s_read(ADDR_CHARGER_STATE_FLAGS) |=> // [RULE3]
            rdata[5:4] == $past({status_in.input_current_limited, status_in.thermal_limited})
            && rdata[2:0] == $past(status_in.charge_code))
        else $error("limit flags or charge code read wrong");

    a_done_read: assert property (s_read(ADDR_CHARGER_STATE_FLAGS) |=> // [RULE4]
            rdata[BIT_CHARGE_DONE] == $past(state.charge_done))
        else $error("charge done read wrong");

    a_code_read: assert property (s_read(ADDR_CHARGER_STATE_FLAGS) |=> // [RULE5]
            rdata[2:0] == $past(status_in.charge_code))
        else $error("charge code read wrong");

    // done latch: set on completion, kept until a new charge starts
    a_done_sets: assert property ( // [RULE4]
            status_in.charge_code == CHG_COMPLETE |=> state.charge_done)
        else $error("charge done not set on completion");

    a_done_sticky: assert property ( // [RULE4]
            state.charge_done
            && status_in.charge_code inside {CHG_COMPLETE, CHG_OFF, CHG_TIMEOUT}
            |=> state.charge_done)
        else $error("charge done dropped without a new charge");

    a_done_clears: assert property ( // [RULE4]
            status_in.charge_code inside {CHG_TRICKLE, CHG_FAST_CC, CHG_FAST_CV}
            |=> !state.charge_done)
        else $error("charge done kept through a new charge");

    // status two: thermistor code, gated recharge info, battery level
    a_thermistor_read: assert property (s_read(ADDR_BATTERY_THERMAL) |=> // [RULE6]
            rdata[7:5] == $past(status_in.thermistor_state_code))
        else $error("thermistor code read wrong");

    a_recharge_gated: assert property ( // [RULE7]
            s_read(ADDR_BATTERY_THERMAL) ##0 !recharge_live
            |=> rdata[3] == 1'b0 && rdata[4] == 1'b0)
        else $error("recharge info active outside completion");

    a_recharge_level: assert property ( // [RULE8]
            s_read(ADDR_BATTERY_THERMAL) ##0 recharge_live
            |=> rdata[3] == $past(status_in.below_recharge)
            && rdata[2:0] == $past(status_in.battery_level_code))
        else $error("recharge info or level code read wrong");

    a_level_read: assert property (s_read(ADDR_BATTERY_THERMAL) |=> // [RULE9]
            rdata[2:0] == $past(status_in.battery_level_code))
        else $error("battery level code read wrong");

    // fault bits: events set them, a host write or a power cycle clears them
    a_short_sets: assert property (short_fire |=> state.fault[BIT_BATTERY_SHORT]) // [RULE10]
        else $error("battery short fault not set");

    a_short_holds: assert property ( // [RULE10]
            state.fault[BIT_BATTERY_SHORT]
            && !(req.wr && req.addr == ADDR_FAULT_FLAGS)
            && !(state.input_good_prev && !status_in.input_good_flag)
            |=> state.fault[BIT_BATTERY_SHORT])
        else $error("short fault dropped without clear");

    a_overtemp_sets: assert property ( // [RULE11]
            status_in.overtemp_high_fault |=> state.fault[BIT_OVERTEMP_HIGH] ##1 1'b1)
        else $error("overtemperature fault not set");

    a_overtemp_low_sets: assert property ( // [RULE11]
            status_in.overtemp_low_fault |=> state.fault[BIT_OVERTEMP_LOW])
        else $error("lower overtemperature fault not set");

    a_fault_read: assert property (s_read(ADDR_FAULT_FLAGS) |=> // [RULE10]
            rdata == $past(state.fault))
        else $error("fault register read wrong");

    a_fault_clears: assert property ( // [RULE12]
            s_clear_fault(BIT_OVERTEMP_HIGH) ##0 !status_in.overtemp_high_fault
            |=> !state.fault[BIT_OVERTEMP_HIGH])
        else $error("write one did not clear fault");

    a_fault_holds: assert property ( // [RULE12]
            state.fault[BIT_OVERTEMP_LOW]
            && !(req.wr && req.addr == ADDR_FAULT_FLAGS)
            && !(state.input_good_prev && !status_in.input_good_flag)
            |=> state.fault[BIT_OVERTEMP_LOW])
        else $error("fault dropped without clear");

    a_power_clears: assert property ( // [RULE12]
            s_supply_drop ##0 !status_in.overtemp_low_fault
            |=> !state.fault[BIT_OVERTEMP_LOW])
        else $error("supply cycle did not clear fault");

    a_fault_unused: assert property (s_read(ADDR_FAULT_FLAGS) |=> // [RULE15]
            rdata[7:4] == 4'h0 && rdata[2] == 1'b0)
        else $error("unused fault bits read non-zero");

    // a write to status two must leave the stored fault and config bits alone
    a_status_write_nop: assert property ( // [RULE15]
            s_write(ADDR_BATTERY_THERMAL) ##0 !short_fire
            && !status_in.overtemp_low_fault && !status_in.overtemp_high_fault
            && !(state.input_good_prev && !status_in.input_good_flag)
            |=> $stable(state.fault) && $stable(state.cfg))
        else $error("status write changed stored bits");

    // short detect config: written whole, unused bits dropped
    a_cfg_write: assert property (s_write(ADDR_SHORT_DETECT_CONFIG) |=> // [RULE13]
            short_timeout_select == $past(req.wdata[7:5])
            && short_threshold_select == $past(req.wdata[2:0]))
        else $error("config write not taken");

    a_selects_stand: assert property ( // [RULE13]
            !(req.wr && req.addr == ADDR_SHORT_DETECT_CONFIG)
            |=> $stable(short_timeout_select) && $stable(short_threshold_select))
        else $error("short selects moved without a config write");

    a_cfg_read: assert property (s_read(ADDR_SHORT_DETECT_CONFIG) |=> // [RULE14]
            rdata == $past(state.cfg))
        else $error("config read wrong");

    a_cfg_kept: assert property ( // [RULE15]
            req.wr && req.addr != ADDR_SHORT_DETECT_CONFIG |=> $stable(state.cfg))
        else $error("config changed by a foreign write");

    a_unused_zero: assert property ( // [RULE15]
            s_read(ADDR_SHORT_DETECT_CONFIG) |=> rdata[4:3] == 2'b00)
        else $error("unused config bits read non-zero");

    // read data stands between strobes, so a slow host may fetch it late
    a_rdata_holds: assert property (!req.rd |=> $stable(rdata))
        else $error("read data changed without a read");

endmodule : charger_status_fault_regs

/* tb/host_model.sv */
`timescale 1ns/1ns
module host_model (
    input  wire logic                  mclk,
    input  wire logic [7:0]            rdata,
    output charger_regs_pkg::reg_req_t req
);
    import charger_regs_pkg::*;

    // idle bus: all fields start at zero; after each access strobes drop and address and data go inverted so stale values never look valid
    initial req = '0;

    // one write strobe; writing 1 to a fault bit is how the host clears it
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask : write_reg

    // one read strobe; data lands on the edge that takes it, so look just after
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hFF};
        #1 data = rdata;
    endtask : read_reg
endmodule : host_model

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import charger_regs_pkg::*;

    // one second shortened to 10 cycles so the timeouts fit the run
    localparam int unsigned SEC = 10;

    logic           mclk;
    logic           rst_n;
    analog_status_t st;
    reg_req_t       req;
    logic [7:0]     rdata;
    logic [2:0]     thr_sel;
    logic [2:0]     tmo_sel;
    int             failures;
    int             check_count;
    int             cycles;
    logic [7:0]     d;

    charger_status_fault_regs #(.SEC_CYCLES(SEC)) dut (
        .mclk(mclk), .rst_n(rst_n), .status_in(st), .req(req), .rdata(rdata),
        .short_threshold_select(thr_sel), .short_timeout_select(tmo_sel));
    host_model host (.mclk(mclk), .rdata(rdata), .req(req));

    // 25 MHz clock
    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic settle();
        repeat (2) @(posedge mclk);
    endtask : settle

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // reset values, unmapped address
    task automatic test_reset();
        host.read_reg(ADDR_SHORT_DETECT_CONFIG, d);
        check("cfg reset", d, 8'h84);
        check("selects reset", {2'h0, tmo_sel, thr_sel}, 8'h24);
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("fault reset", d, 8'h00);
        host.read_reg(8'h3F, d);
        check("unmapped", d, 8'h00);
        $display("test reset done");
    endtask : test_reset

    // every charge code, flags and the latching end-of-charge bit
    task automatic test_status_one();
        logic [2:0] i;
        logic [7:0] want;
        for (int k = 0; k < 10; k++) begin
            i = (k < 8) ? k[2:0] : k[2:0] - 3'h7;
            @(posedge mclk);
            st.input_overvoltage_flag <= i[0];
            st.input_good_flag <= i[1];
            st.input_current_limited <= i[2];
            st.thermal_limited <= ~i[0];
            st.charge_code <= charge_code_t'(i);
            settle();
            host.read_reg(ADDR_CHARGER_STATE_FLAGS, d);
            // done holds through regulator, timeout and detection, a new charge drops it
            want = {i[0], i[1], i[2], ~i[0], (k >= 4 && k < 8), i};
            check("status one", d, want);
        end
        $display("test status one done");
    endtask : test_status_one

    // thermistor and battery codes, recharge info gating, writes ignored
    task automatic test_status_two();
        logic [2:0] tc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
        logic       rb;
        logic [7:0] want;
        for (int k = 0; k < 6; k++) begin
            @(posedge mclk);
            st.thermistor_state_code <= tc[k];
            st.battery_level_code <= (k < 5) ? k[2:0] : 3'h1;
            st.recharge_disable <= (k != 2);
            st.charge_code <= (k == 3) ? CHG_FAST_CV : CHG_COMPLETE;
            st.below_recharge <= (k != 1);
            rb = (k != 1) && (k != 2) && (k != 3);
            settle();
            host.write_reg(ADDR_BATTERY_THERMAL, 8'hFF);
            host.read_reg(ADDR_BATTERY_THERMAL, d);
            want = {tc[k], 1'b0, rb, (k < 5) ? k[2:0] : 3'h1};
            check("status two", d, want);
        end
        $display("test status two done");
    endtask : test_status_two

    // overtemp faults latch, clear by write one or by supply cycling
    task automatic test_faults();
        @(posedge mclk);
        st.overtemp_low_fault <= 1'b1;
        @(posedge mclk);
        st.overtemp_low_fault <= 1'b0;
        settle();
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("fault low", d, 8'h02);
        @(posedge mclk);
        st.overtemp_high_fault <= 1'b1;
        @(posedge mclk);
        st.overtemp_high_fault <= 1'b0;
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("fault both", d, 8'h03);
        host.write_reg(ADDR_FAULT_FLAGS, 8'h01);
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("fault w1c", d, 8'h02);
        host.write_reg(ADDR_FAULT_FLAGS, 8'hF4);
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("fault unused", d, 8'h02);
        @(posedge mclk);
        st.input_good_flag <= 1'b1;
        settle();
        st.input_good_flag <= 1'b0;
        settle();
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("fault power", d, 8'h00);
        $display("test faults done");
    endtask : test_faults

    // config register fields and the select outputs
    task automatic test_config();
        host.write_reg(ADDR_SHORT_DETECT_CONFIG, 8'hFF);
        host.read_reg(ADDR_SHORT_DETECT_CONFIG, d);
        check("cfg ones", d, 8'hE7);
        check("selects ones", {2'h0, tmo_sel, thr_sel}, 8'h3F);
        host.write_reg(ADDR_SHORT_DETECT_CONFIG, 8'h00);
        host.read_reg(ADDR_SHORT_DETECT_CONFIG, d);
        check("cfg zero", d, 8'h00);
        check("selects zero", {2'h0, tmo_sel, thr_sel}, 8'h00);
        $display("test config done");
    endtask : test_config

    // short fault: a dip restarts the 2 s wait, an unbroken wait sets it
    task automatic test_short();
        host.write_reg(ADDR_SHORT_DETECT_CONFIG, 8'h20);
        @(posedge mclk);
        st.below_short <= 1'b1;
        repeat (15) @(posedge mclk);
        st.below_short <= 1'b0;
        @(posedge mclk);
        st.below_short <= 1'b1;
        repeat (15) @(posedge mclk);
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("short early", d, 8'h00);
        repeat (10) @(posedge mclk);
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("short set", d, 8'h08);
        @(posedge mclk);
        st.below_short <= 1'b0;
        host.write_reg(ADDR_FAULT_FLAGS, 8'h08);
        host.read_reg(ADDR_FAULT_FLAGS, d);
        check("short clear", d, 8'h00);
        $display("test short done");
    endtask : test_short

    // hang guard, far above the roughly 200 cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        st = '0;
        failures = 0;
        check_count = 0;
        cycles = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        test_reset();
        test_status_one();
        test_status_two();
        test_faults();
        test_config();
        test_short();
        results();
    end
endmodule : testbench
